// ==== logic/acp_pkg.sv ====
/*
 * Constants of the serial configuration port: register offsets, reset values,
 * instruction word layout and synchroniser figures.
 * Assumes it is compiled before every file that names acp_pkg.
 */
package acp_pkg;

    // ==========================================================================
    // Register offsets.
    localparam logic [7:0] REG_CHIP_CFG      = 8'h00;
    localparam logic [7:0] REG_CHIP_ID       = 8'h01;
    localparam logic [7:0] REG_CHIP_GRADE    = 8'h02;
    localparam logic [7:0] REG_DEV_INDEX     = 8'h05;
    localparam logic [7:0] REG_FUNC_FIRST    = 8'h08;
    localparam logic [7:0] REG_CLOCK_CONTROL = 8'h09;
    localparam logic [7:0] REG_FUNC_LAST     = 8'h22;
    localparam logic [7:0] REG_TRANSFER      = 8'hff;

    // ==========================================================================
    // Reset values and fields.
    localparam logic [7:0] CLOCK_CONTROL_RST = 8'h01;
    localparam logic [7:0] OTHER_RST         = 8'h00;
    localparam int         CFG_LSB_FIRST_BIT = 6;

    // ==========================================================================
    // Instruction word layout: read flag, two length bits, address.
    localparam int         INSTR_BITS        = 16;
    localparam int         INSTR_RD_BIT      = 15;
    localparam int         LENGTH_BIT_HIGH   = 14;
    localparam int         LENGTH_BIT_LOW    = 13;
    localparam logic [3:0] INSTR_LAST_CNT    = 4'hf;
    localparam logic [3:0] BYTE_LAST_CNT     = 4'h7;
    localparam logic [1:0] LEN_STREAM        = 2'h3;

    // ==========================================================================
    // Pin handling: {data, shift clock, chip select} inactive levels.
    localparam logic [2:0] PIN_TERM_LEVEL    = 3'h1;
    localparam logic [1:0] STRAP_WAIT_CNT    = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INSTR,
        ST_DATA,
        ST_DONE
    } acp_state_type;

endpackage

// ==== logic/acp_serial_port.sv ====
/*
 * Serial configuration port of a quad converter and its register map.
 * The shift clock, chip-select and data pin come from an outside controller
 * and are sampled by i_ref_clk; the shift clock must stay well below a
 * quarter of the sampling rate.
 */
`timescale 1ns/1ps

module acp_serial_port #(
    parameter logic [7:0] CHIP_ID_VALUE = 8'h5a  // Arbitrary identity value.
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_shift_clk,
    input  wire logic       i_data_pin,
    output logic            o_data_pin,
    output logic            o_data_pin_oe,
    output logic [7:0]      o_clock_control,
    output logic            o_strap_mode,
    output logic            o_output_drive_mode_strap,
    output logic            o_test_pattern_strap
);

    // ==========================================================================
    // Pin synchronisers, index 0 chip select, 1 shift clock, 2 data.
    logic [2:0]                 sync1_r;
    logic [2:0]                 sync2_r;
    logic [2:0]                 sync3_r;
    logic [2:0]                 pin_r;
    logic [2:0]                 pin_d_r;

    // Three stages per pin; a level is accepted once stages two and three agree.
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge i_ref_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                sync1_r[g] <= acp_pkg::PIN_TERM_LEVEL[g];
                sync2_r[g] <= acp_pkg::PIN_TERM_LEVEL[g];
                sync3_r[g] <= acp_pkg::PIN_TERM_LEVEL[g];
                pin_r[g]   <= acp_pkg::PIN_TERM_LEVEL[g];
                pin_d_r[g] <= acp_pkg::PIN_TERM_LEVEL[g];
            end else begin
                sync1_r[g] <= g == 0 ? i_chip_select_n : (g == 1 ? i_shift_clk : i_data_pin);
                sync2_r[g] <= sync1_r[g];
                sync3_r[g] <= sync2_r[g];
                pin_r[g]   <= (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : pin_r[g];
                pin_d_r[g] <= pin_r[g];
            end
        end
    end

    // ==========================================================================
    // Strap capture: chip select seen high just after reset locks strap mode.
    logic [1:0]                 strap_cnt_r;
    logic                       ready_r;
    logic                       strap_r;

    // The decision takes the level pin_r is about to hold, so its reset value decides the mode only when stages two and three disagree.
    wire                        cs_settled = (sync2_r[0] == sync3_r[0]) ? sync3_r[0] : pin_r[0];

    // The wait lets the synchroniser fill before the level is believed.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_cnt_r <= 2'h0;
            ready_r     <= 1'b0;
            strap_r     <= 1'b0;
        end else if (!ready_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == acp_pkg::STRAP_WAIT_CNT) begin
                ready_r <= 1'b1;
                strap_r <= cs_settled;
            end
        end
    end

    // In strap mode the clock and data pins carry static options, not traffic.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_strap_mode              <= 1'b0;
            o_output_drive_mode_strap <= 1'b0;
            o_test_pattern_strap      <= 1'b0;
        end else begin
            o_strap_mode              <= strap_r;
            o_output_drive_mode_strap <= strap_r & pin_r[2];
            o_test_pattern_strap      <= strap_r & pin_r[1];
        end
    end

    // ==========================================================================
    // Register map storage and decode.
    logic [7:0]                 mem_r [0:255];
    acp_pkg::acp_state_type     state_r;
    logic [3:0]                 bit_cnt_r;
    logic [15:0]                shift_r;
    logic [7:0]                 addr_r;
    logic                       rd_r;
    logic [1:0]                 len_r;
    logic [1:0]                 byte_cnt_r;
    logic [7:0]                 tx_r;

    function automatic logic is_defined(input logic [7:0] a);
        is_defined = (a <= acp_pkg::REG_CHIP_GRADE) || (a == acp_pkg::REG_DEV_INDEX)
                   || (a == acp_pkg::REG_TRANSFER)
                   || (a >= acp_pkg::REG_FUNC_FIRST && a <= acp_pkg::REG_FUNC_LAST);
    endfunction

    function automatic logic [7:0] default_of(input int a);
        if (a == int'(acp_pkg::REG_CLOCK_CONTROL)) default_of = acp_pkg::CLOCK_CONTROL_RST;
        else if (a == int'(acp_pkg::REG_CHIP_ID)) default_of = CHIP_ID_VALUE;
        else default_of = acp_pkg::OTHER_RST;
    endfunction

    // Engine conditions, all on the synchronised pin levels.
    wire        csb_n      = pin_r[0];
    wire        sdi        = pin_r[2];
    wire        sclk_rise  = pin_r[1] & ~pin_d_r[1];
    wire        sclk_fall  = ~pin_r[1] & pin_d_r[1];
    wire        port_live  = ready_r & ~strap_r & ~csb_n;
    wire        lsb_first  = mem_r[acp_pkg::REG_CHIP_CFG][acp_pkg::CFG_LSB_FIRST_BIT];
    wire [15:0] shift_nxt  = lsb_first ? {sdi, shift_r[15:1]} : {shift_r[14:0], sdi};
    wire [7:0]  byte_in    = lsb_first ? shift_nxt[15:8] : shift_nxt[7:0];
    wire [7:0]  ins_addr   = shift_nxt[7:0];
    wire [1:0]  ins_len    = {shift_nxt[acp_pkg::LENGTH_BIT_HIGH], shift_nxt[acp_pkg::LENGTH_BIT_LOW]};
    wire        ins_rd     = shift_nxt[acp_pkg::INSTR_RD_BIT];
    wire        instr_end  = (state_r == acp_pkg::ST_INSTR) && sclk_rise
                             && (bit_cnt_r == acp_pkg::INSTR_LAST_CNT);
    wire        byte_end   = (state_r == acp_pkg::ST_DATA) && sclk_rise
                             && (bit_cnt_r == acp_pkg::BYTE_LAST_CNT);
    wire        last_byte  = (len_r != acp_pkg::LEN_STREAM) && (byte_cnt_r == len_r);
    wire [7:0]  addr_next  = addr_r + 8'h01;
    wire [7:0]  rd_addr    = instr_end ? ins_addr : addr_next;
    wire [7:0]  rd_data    = is_defined(rd_addr) ? mem_r[rd_addr] : 8'h00;
    wire        read_only  = (addr_r == acp_pkg::REG_CHIP_ID) || (addr_r == acp_pkg::REG_CHIP_GRADE);
    wire        wr_en      = byte_end && port_live && !rd_r && is_defined(addr_r) && !read_only;

    // Registers take their defaults under reset, so they hold them before any frame.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 256; i++) begin
                mem_r[i] <= default_of(i);
            end
        end else if (wr_en) begin
            mem_r[addr_r] <= byte_in;
        end
    end

    assign o_clock_control = mem_r[acp_pkg::REG_CLOCK_CONTROL];

    // ==========================================================================
    // Frame engine: instruction, then data bytes on rising edges.
    // Chip select high at any point drops the frame; partial bytes are lost.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r    <= acp_pkg::ST_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 16'h0000;
            addr_r     <= 8'h00;
            rd_r       <= 1'b0;
            len_r      <= 2'h0;
            byte_cnt_r <= 2'h0;
        end else if (!port_live) begin
            state_r    <= acp_pkg::ST_IDLE;
            bit_cnt_r  <= 4'h0;
        end else begin
            unique case (state_r)
                acp_pkg::ST_IDLE: begin
                    state_r   <= acp_pkg::ST_INSTR;
                    bit_cnt_r <= 4'h0;
                end
                acp_pkg::ST_INSTR: begin
                    if (sclk_rise) begin
                        shift_r   <= shift_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (instr_end) begin
                        addr_r     <= ins_addr;
                        rd_r       <= ins_rd;
                        len_r      <= ins_len;
                        byte_cnt_r <= 2'h0;
                        bit_cnt_r  <= 4'h0;
                        state_r    <= acp_pkg::ST_DATA;
                    end
                end
                acp_pkg::ST_DATA: begin
                    if (sclk_rise) begin
                        shift_r   <= shift_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (byte_end) begin
                        bit_cnt_r  <= 4'h0;
                        addr_r     <= addr_next;
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        if (last_byte) begin
                            state_r <= acp_pkg::ST_DONE;
                        end
                    end
                end
                acp_pkg::ST_DONE: begin
                    bit_cnt_r <= 4'h0;  // Extra clocks are ignored until chip select rises.
                end
            endcase
        end
    end

    // ==========================================================================
    // Readback driver: pin turns to output after a falling edge and is released
    // after the rising edge that ends the last byte, or when chip select rises.
    wire drive_bit = port_live && rd_r && (state_r == acp_pkg::ST_DATA) && sclk_fall;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_r          <= 8'h00;
            o_data_pin    <= 1'b0;
            o_data_pin_oe <= 1'b0;
        end else if (!port_live) begin
            o_data_pin_oe <= 1'b0;
        end else if (instr_end || byte_end) begin
            tx_r <= rd_data;
            if (byte_end && last_byte) begin
                o_data_pin_oe <= 1'b0;
            end
        end else if (drive_bit) begin
            o_data_pin_oe <= 1'b1;
            o_data_pin    <= lsb_first ? tx_r[0] : tx_r[7];
            tx_r          <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        end
    end

endmodule // acp_serial_port

// ==== sim/acp_ctrl_model.sv ====
/* Behavioural programming controller that drives the serial port pins.
   Assumes the bench resolves the shared data pin and feeds it back here. */
`timescale 1ns/1ps

module acp_ctrl_model (
    output logic            o_chip_select_n,
    output logic            o_shift_clk,
    output logic            o_data,
    output logic            o_data_en,
    input  wire logic       i_data_pin
);
    // ==========================================================================
    // Pins idle with the clock stopped low and the data line released.
    logic lsb_first = 1'b0;
    initial begin
        o_chip_select_n = 1'b1;
        o_shift_clk = 1'b0;
        o_data = 1'b0;
        o_data_en = 1'b0;
    end

    task automatic set_pins(input logic cs, input logic d, input logic en);
        o_chip_select_n = cs;
        o_shift_clk = 1'b0;
        o_data = d;
        o_data_en = en;
    endtask

    // One bit of 160 ns; data set at the fall, held past the rise.
    task automatic put_bit(input logic b, input logic drive, output logic got);
        o_shift_clk = 1'b0;
        o_data = b;
        o_data_en = drive;
        #75 got = i_data_pin;
        #5 o_shift_clk = 1'b1;
        #80;
    endtask

    // Instruction then nbits of data; nbits short of a byte aborts mid-byte.
    task automatic xfer(input logic [15:0] ins, input int nbits, input logic [31:0] wd, output logic [31:0] rd);
        logic g;
        int i;
        int k;
        rd = 32'h0;
        o_chip_select_n = 1'b0;
        #43;
        for (i = 0; i < 16; i++) put_bit(ins[lsb_first ? i : 15 - i], 1'b1, g);
        for (i = 0; i < nbits; i++) begin
            k = 31 - 8 * (i / 8) - (lsb_first ? 7 - i % 8 : i % 8);
            put_bit(wd[k], !ins[15], g);
            rd[k] = g;
        end
        // Chip select rises while the clock is still high, so no falling edge starts another readback bit.
        o_data_en = 1'b0;
        #40 o_chip_select_n = 1'b1;
        #40 o_shift_clk = 1'b0;
        #260;
    endtask
endmodule // acp_ctrl_model

// ==== sim/acp_serial_port_checker.sv ====
/* Concurrent checks on the ports of acp_serial_port, bound at the foot.
   Assumes shift clock half periods of at least eight reference clocks. */
`timescale 1ns/1ps

module acp_serial_port_checker (
    input wire logic       i_ref_clk,
    input wire logic       i_rstn,
    input wire logic       i_chip_select_n,
    input wire logic       i_shift_clk,
    input wire logic       o_data_pin,
    input wire logic       o_data_pin_oe,
    input wire logic [7:0] o_clock_control,
    input wire logic       o_strap_mode,
    input wire logic       o_output_drive_mode_strap,
    input wire logic       o_test_pattern_strap
);
    // ==========================================================================
    // Idle count of chip select; it saturates at eight so it never wraps.
    logic [3:0] cs_hi_r;
    logic [3:0] cs_hi_nxt;
    assign cs_hi_nxt = !i_chip_select_n ? 4'h0 : (cs_hi_r == 4'h8 ? cs_hi_r : cs_hi_r + 4'h1);
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) cs_hi_r <= 4'h0;
        else cs_hi_r <= cs_hi_nxt;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // ==========================================================================
    // The pin turns round only while the shift clock is low.
    sequence s_read_turn;
        $rose(o_data_pin_oe);
    endsequence

    cc_reset_a: assert property (!$past(i_rstn) |-> o_clock_control == 8'h01)
        else $error("clock control not at default after reset");
    oe_idle_a: assert property (cs_hi_r == 4'h8 |-> !o_data_pin_oe)
        else $error("data pin driven with chip select idle");
    cc_hold_a: assert property (cs_hi_r == 4'h8 |-> $stable(o_clock_control))
        else $error("clock control changed outside a frame");
    read_turn_a: assert property (s_read_turn |-> !i_shift_clk && !i_chip_select_n)
        else $error("data pin enabled away from a falling edge");
    read_release_a: assert property ($fell(o_data_pin_oe) |-> i_shift_clk || i_chip_select_n)
        else $error("data pin released away from a rising edge");
    data_change_a: assert property ($changed(o_data_pin) && o_data_pin_oe && $past(o_data_pin_oe) |-> !i_shift_clk)
        else $error("read data changed while shift clock high");
    strap_zero_a: assert property (!o_strap_mode |-> !o_output_drive_mode_strap && !o_test_pattern_strap)
        else $error("strap outputs active outside strap mode");
    strap_quiet_a: assert property (o_strap_mode |-> !o_data_pin_oe)
        else $error("data pin driven in strap mode");
endmodule // acp_serial_port_checker

bind acp_serial_port acp_serial_port_checker u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_chip_select_n(i_chip_select_n), .i_shift_clk(i_shift_clk), .o_data_pin(o_data_pin),
    .o_data_pin_oe(o_data_pin_oe), .o_clock_control(o_clock_control), .o_strap_mode(o_strap_mode),
    .o_output_drive_mode_strap(o_output_drive_mode_strap), .o_test_pattern_strap(o_test_pattern_strap));

// ==== sim/acp_serial_port_tb.sv ====
/* Self-checking bench for acp_serial_port with a controller model.
   Assumes a 100 MHz reference clock and a 160 ns shift clock. */
`timescale 1ns/1ps

module acp_serial_port_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    wire cs_n, sclk, sdo, sdo_en, d_oe, d_out, pin, strap, output_drive_mode_strap, test_pattern_strap;
    wire [7:0] cc;

    // ==========================================================================
    // The device wins when enabled, then the controller, else termination low.
    assign pin = d_oe ? d_out : (sdo_en ? sdo : 1'b0);
    always #5 clk = ~clk;

    acp_ctrl_model ctl (.o_chip_select_n(cs_n), .o_shift_clk(sclk), .o_data(sdo), .o_data_en(sdo_en),
        .i_data_pin(pin));
    acp_serial_port uut (.i_ref_clk(clk), .i_rstn(rstn), .i_chip_select_n(cs_n), .i_shift_clk(sclk),
        .i_data_pin(pin), .o_data_pin(d_out), .o_data_pin_oe(d_oe), .o_clock_control(cc),
        .o_strap_mode(strap), .o_output_drive_mode_strap(output_drive_mode_strap), .o_test_pattern_strap(test_pattern_strap));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // A hang is cut short well beyond the roughly 20k cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            finish_test();
        end
    end

    // Chip select level at release picks strap or serial mode.
    task automatic do_reset(input logic strap_cs);
        @(posedge clk) #1 rstn = 1'b0;
        ctl.set_pins(strap_cs, 1'b1, 1'b1);
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (10) @(posedge clk);
        if (!strap_cs) ctl.set_pins(1'b1, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
    endtask

    // ==========================================================================
    // Scenarios.
    task automatic t_basic;
        logic [31:0] r;
        chk({strap, cc}, 32'h01);
        ctl.xfer(16'h8009, 8, 32'h0, r);
        chk(r, 32'h01000000);
        ctl.xfer(16'h0000, 8, 32'h0, r);
        ctl.xfer(16'h0009, 8, 32'ha5000000, r);
        chk(cc, 32'ha5);
        ctl.xfer(16'h8009, 8, 32'h0, r);
        chk(r, 32'ha5000000);
    endtask

    // Defined places hold data, the read-only grade place and undefined places read zero.
    task automatic t_map;
        logic [31:0] r;
        logic [7:0] adr [8] = '{8'h05, 8'hff, 8'h08, 8'h22, 8'h02, 8'h23, 8'h06, 8'h03};
        int i;
        for (i = 0; i < 8; i++) begin
            if (i < 5) ctl.xfer({8'h00, adr[i]}, 8, {adr[i] ^ 8'h3c, 24'h0}, r);
            ctl.xfer({8'h80, adr[i]}, 8, 32'h0, r);
            chk(r, (i < 4) ? {adr[i] ^ 8'h3c, 24'h0} : 32'h0);
        end
    endtask

    // Every length code, with surplus clocks that must be ignored.
    task automatic t_length;
        logic [31:0] r;
        logic [31:0] d;
        int len;
        for (len = 0; len < 4; len++) begin
            d = 32'h5a6b7c8d + len;
            ctl.xfer(16'h6008, 32, 32'h0, r);
            ctl.xfer({1'b0, len[1:0], 13'h0008}, 32, d, r);
            ctl.xfer(16'he008, 32, 32'h0, r);
            chk(r, d & ~(32'hffffffff >> (8 * (len + 1))));
        end
        chk(cc, {24'h0, d[23:16]});
    endtask

    task automatic t_abort_lsb;
        logic [31:0] r;
        ctl.xfer(16'h0009, 8, 32'h3e000000, r);
        ctl.xfer(16'h0009, 4, 32'hf0000000, r);
        chk(cc, 32'h3e);
        ctl.xfer(16'h8009, 8, 32'h0, r);
        chk(r, 32'h3e000000);
        ctl.xfer(16'h0000, 8, 32'h40000000, r);
        ctl.lsb_first = 1'b1;
        ctl.xfer(16'h0009, 8, 32'hc5000000, r);
        chk(cc, 32'hc5);
        ctl.xfer(16'h8009, 8, 32'h0, r);
        chk(r, 32'hc5000000);
        ctl.xfer(16'h0000, 8, 32'h0, r);
        ctl.lsb_first = 1'b0;
    endtask

    task automatic t_strap;
        logic [31:0] r;
        do_reset(1'b1);
        chk({strap, output_drive_mode_strap, test_pattern_strap}, 32'h6);
        ctl.xfer(16'h0009, 8, 32'h77000000, r);
        chk(cc, 32'h01);
        ctl.o_shift_clk = 1'b1;
        repeat (10) @(posedge clk);
        chk({strap, output_drive_mode_strap, test_pattern_strap}, 32'h5);
        do_reset(1'b0);
        chk({strap, cc}, 32'h01);
    endtask

    initial begin
        do_reset(1'b0);
        t_basic();
        t_map();
        t_length();
        t_abort_lsb();
        t_strap();
        finish_test();
    end
endmodule // acp_serial_port_tb
